// *** common/clkgen_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts
 * of the machine clock generator.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// =====================================================================
// Register byte offsets
`define PLL_CONFIG_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define BANK_SWITCH_OFFSET 12'h008

// =====================================================================
// Field positions
`define CFG_PLL_EN_BIT 0
`define CFG_DIV4_BIT 1
`define CFG_MULT_LSB 4
`define CFG_MULT_MSB 9
`define STAT_LOCKED_BIT 0
`define STAT_PLL_ON_BIT 1
`define STAT_STRAP_BIT 2
`define STAT_PERIOD_LSB 16
`define STAT_PERIOD_MSB 31

// =====================================================================
// Reset values and limits
`define OUT_DIV_RESET 2'h3
`define OUT_DIV_UNDIVIDED 2'h0
`define MULT_MIN_Q 6'h04

// =====================================================================
// Timing
`define CLK_FREQ_HZ 25000000
`define LOCK_TIME_MS 30
`define LOCK_CYCLES_DEF (`LOCK_TIME_MS * (`CLK_FREQ_HZ / 1000))

`endif

// *** common/clkgen_pkg.sv ***
/*
 * Types shared by the machine clock generator.
 * Assumes nothing of its surroundings.
 */
package clkgen_pkg;
    typedef enum logic [1:0] {MODE_DIV2, MODE_DIV4, MODE_PLL} clk_mode_e;
    typedef logic [5:0] mult_t;
endpackage

// *** src/machine_clock_generator.sv ***
/*
 * Machine clock generator: divides or multiplies the reference clock,
 * with an AHB-Lite register slave, strap sampling and lock timing.
 * Assumes the reference clock is far slower than CLK, and a single
 * AHB-Lite master whose HREADY is this slave's HREADYOUT.
 */
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
// Behaviour
// [R1] Bypassed PLL divides reference by two or four
// [R2] Pins 000,111 give /2; 101 gives /4
// [R3] PLL mode multiplies reference by factor N
// [R4] N integer 1-15 plus quarter fractions
// [R5] Software may reprogram multiplier while running
// [R6] Lock-up phase at most 30 ms
// [R7] Output field 00 gives undivided machine clock
// [R8] Output field resets to divide-by-four
// [R9] Mode pins are sampled at reset release
// [R10] Config register bits set active multiply ratio
// [R11] Other pin codes select PLL multiply factors
`timescale 1ns/1ps
`include "clkgen_regs.svh"

module machine_clock_generator
    import clkgen_pkg::*;
#(
    parameter int LOCK_CYCLES = `LOCK_CYCLES_DEF
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic REFERENCE_CLOCK_INPUT,
    input wire logic MODE_SELECT_PIN_A,
    input wire logic MODE_SELECT_PIN_B,
    input wire logic MODE_SELECT_PIN_C,
    output logic MACHINE_CLOCK,
    output logic MACHINE_CLOCK_OUTPUT,
    output logic PLL_LOCKED
);

    // =================================================================
    // Pin synchronisers
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic ref_last;
    logic ref_rise;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            ref_last <= 1'b0;
        end else begin
            sync1 <= {REFERENCE_CLOCK_INPUT, MODE_SELECT_PIN_A, MODE_SELECT_PIN_B, MODE_SELECT_PIN_C};
            sync2 <= sync1;
            ref_last <= sync2[3];
        end
    end

    assign ref_rise = sync2[3] && !ref_last;

    // =================================================================
    // Strap decode
    logic strap_done;
    logic strap_take;
    clk_mode_e strap_mode;
    mult_t strap_mult;

    always_comb begin
        strap_mode = MODE_PLL;
        strap_mult = 6'h04;
        unique case (sync2[2:0])
            3'h0: strap_mode = MODE_DIV2; // [R2]
            3'h5: strap_mode = MODE_DIV4; // [R2]
            3'h7: strap_mode = MODE_DIV2; // [R2]
            3'h1: strap_mult = 6'h08; // [R11]
            3'h2: strap_mult = 6'h0c; // [R11]
            3'h3: strap_mult = 6'h10; // [R11]
            3'h4: strap_mult = 6'h14; // [R11]
            3'h6: strap_mult = 6'h04; // [R11]
        endcase
    end

    // Pins settle through the synchroniser before being caught
    logic [1:0] strap_wait;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
        end else begin
            if (strap_wait != 2'h3) begin
                strap_wait <= strap_wait + 2'h1;
            end
            if (strap_take) begin
                strap_done <= 1'b1;
            end
        end
    end

    assign strap_take = (strap_wait == 2'h3) && !strap_done; // [R9]

    // =================================================================
    // AHB-Lite slave
    logic dp_wr;
    logic [11:0] dp_addr;
    logic addr_valid;
    logic cfg_write;
    logic [31:0] cfg;
    logic [1:0] out_div;
    logic [31:0] status;
    logic [15:0] ref_period;

    assign addr_valid = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dp_wr <= 1'b0;
            dp_addr <= 12'h000;
        end else begin
            dp_wr <= addr_valid && HWRITE;
            dp_addr <= HADDR;
        end
    end

    always_comb begin
        status = 32'h0;
        status[`STAT_LOCKED_BIT] = PLL_LOCKED;
        status[`STAT_PLL_ON_BIT] = cfg[`CFG_PLL_EN_BIT];
        status[`STAT_STRAP_BIT] = strap_done;
        status[`STAT_PERIOD_MSB:`STAT_PERIOD_LSB] = ref_period;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            HRDATA <= 32'h0;
        end else if (addr_valid && !HWRITE) begin
            unique case (HADDR)
                `PLL_CONFIG_OFFSET: HRDATA <= cfg;
                `STATUS_OFFSET: HRDATA <= status;
                `BANK_SWITCH_OFFSET: HRDATA <= {30'h0, out_div};
                default: HRDATA <= 32'h0;
            endcase
        end
    end

    assign cfg_write = dp_wr && (dp_addr == `PLL_CONFIG_OFFSET);

    // Config register: strap loads it once, software rewrites it
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg <= 32'h0;
        end else if (strap_take) begin
            cfg <= 32'h0;
            cfg[`CFG_PLL_EN_BIT] <= (strap_mode == MODE_PLL); // [R9]
            cfg[`CFG_DIV4_BIT] <= (strap_mode == MODE_DIV4);
            cfg[`CFG_MULT_MSB:`CFG_MULT_LSB] <= strap_mult;
        end else if (cfg_write) begin
            cfg <= {22'h0, HWDATA[`CFG_MULT_MSB:`CFG_MULT_LSB], 2'h0, HWDATA[1:0]}; // [R5]
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_div <= `OUT_DIV_RESET; // [R8]
        end else if (dp_wr && dp_addr == `BANK_SWITCH_OFFSET) begin
            out_div <= HWDATA[1:0];
        end
    end

    // =================================================================
    // Reference period measurement
    logic [15:0] period_cnt;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            period_cnt <= 16'h0;
            ref_period <= 16'h0;
        end else if (ref_rise) begin
            period_cnt <= 16'h1;
            ref_period <= period_cnt;
        end else if (period_cnt != 16'hffff) begin
            period_cnt <= period_cnt + 16'h1;
        end
    end

    // =================================================================
    // Machine clock: divider or fractional multiplier
    mult_t mult_q;
    logic [19:0] acc;
    logic [19:0] next_acc;
    logic [19:0] limit;
    logic pll_evt;
    logic div_evt;
    logic mach_evt;
    logic div_phase;

    // Multiplier in quarter steps: N = mult_q / 4
    assign mult_q = (cfg[`CFG_MULT_MSB:`CFG_MULT_LSB] < `MULT_MIN_Q) ?
                    `MULT_MIN_Q : cfg[`CFG_MULT_MSB:`CFG_MULT_LSB]; // [R4] [R10]
    assign limit = {2'h0, ref_period, 2'h0};
    assign next_acc = acc + {13'h0, mult_q, 1'b0};
    assign pll_evt = cfg[`CFG_PLL_EN_BIT] && (ref_period != 16'h0) && (next_acc >= limit); // [R3]
    assign div_evt = !cfg[`CFG_PLL_EN_BIT] && ref_rise && (!cfg[`CFG_DIV4_BIT] || div_phase); // [R1]
    assign mach_evt = pll_evt || div_evt;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc <= 20'h0;
        end else if (!cfg[`CFG_PLL_EN_BIT]) begin
            acc <= 20'h0;
        end else if (pll_evt) begin
            acc <= next_acc - limit; // [R3]
        end else begin
            acc <= next_acc;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_phase <= 1'b0;
        end else if (ref_rise) begin
            div_phase <= !div_phase; // [R1]
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            MACHINE_CLOCK <= 1'b0;
        end else if (mach_evt) begin
            MACHINE_CLOCK <= !MACHINE_CLOCK;
        end
    end

    // =================================================================
    // Clock output divider: toggles every out_div+1 machine edges
    logic [1:0] out_cnt;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_cnt <= 2'h0;
            MACHINE_CLOCK_OUTPUT <= 1'b0;
        end else if (mach_evt) begin
            if (out_cnt >= out_div) begin
                out_cnt <= 2'h0;
                MACHINE_CLOCK_OUTPUT <= !MACHINE_CLOCK_OUTPUT; // [R7]
            end else begin
                out_cnt <= out_cnt + 2'h1;
            end
        end
    end

    // =================================================================
    // Lock timer
    logic [23:0] lock_cnt;
    logic relock;
    assign relock = strap_take || cfg_write;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lock_cnt <= 24'h0;
            PLL_LOCKED <= 1'b0;
        end else if (relock) begin
            lock_cnt <= 24'(LOCK_CYCLES - 1); // [R6]
            PLL_LOCKED <= 1'b0;
        end else if (lock_cnt != 24'h0) begin
            lock_cnt <= lock_cnt - 24'h1;
        end else if (strap_done) begin
            PLL_LOCKED <= 1'b1; // [R6]
        end
    end

    // =================================================================
    // Assertions
    property p_div_edges;
        @(posedge CLK) disable iff (!RESET_N)
        !$past(cfg[`CFG_PLL_EN_BIT]) && $changed(MACHINE_CLOCK) |-> $past(ref_rise);
    endproperty
    a_div_edges: assert property (p_div_edges) else $error("divide mode edge without reference edge"); // [R1]

    property p_strap_div4;
        @(posedge CLK) disable iff (!RESET_N)
        strap_take && sync2[2:0] == 3'h5 |=> !cfg[`CFG_PLL_EN_BIT] && cfg[`CFG_DIV4_BIT];
    endproperty
    a_strap_div4: assert property (p_strap_div4) else $error("pins 101 did not select divide by four"); // [R2]

    property p_pll_rate;
        @(posedge CLK) disable iff (!RESET_N)
        $past(cfg[`CFG_PLL_EN_BIT]) && $changed(MACHINE_CLOCK) |->
            $past(ref_period) != 16'h0 && $past(next_acc) >= $past(limit);
    endproperty
    a_pll_rate: assert property (p_pll_rate) else $error("multiplier edge early"); // [R3]

    property p_mult_min;
        @(posedge CLK) disable iff (!RESET_N)
        mult_q >= `MULT_MIN_Q;
    endproperty
    a_mult_min: assert property (p_mult_min) else $error("multiplier below one"); // [R4]

    property p_reprogram;
        @(posedge CLK) disable iff (!RESET_N)
        cfg_write && !strap_take |=> cfg[`CFG_MULT_MSB:`CFG_MULT_LSB] == $past(HWDATA[`CFG_MULT_MSB:`CFG_MULT_LSB]);
    endproperty
    a_reprogram: assert property (p_reprogram) else $error("multiplier write lost"); // [R5] [R10]

    property p_lock_low;
        @(posedge CLK) disable iff (!RESET_N)
        relock |=> !PLL_LOCKED [*8];
    endproperty
    a_lock_low: assert property (p_lock_low) else $error("lock flag rose too soon"); // [R6]

    property p_lock_bound;
        @(posedge CLK) disable iff (!RESET_N)
        lock_cnt <= 24'(LOCK_CYCLES);
    endproperty
    a_lock_bound: assert property (p_lock_bound) else $error("lock time exceeds limit"); // [R6]

    property p_undivided;
        @(posedge CLK) disable iff (!RESET_N)
        out_div == `OUT_DIV_UNDIVIDED && mach_evt |=> $changed(MACHINE_CLOCK_OUTPUT);
    endproperty
    a_undivided: assert property (p_undivided) else $error("undivided output missed an edge"); // [R7]

    property p_out_reset;
        @(posedge CLK)
        $rose(RESET_N) |-> out_div == `OUT_DIV_RESET;
    endproperty
    a_out_reset: assert property (p_out_reset) else $error("output divide not four after reset"); // [R8]

    property p_strap_once;
        @(posedge CLK) disable iff (!RESET_N)
        strap_take |=> strap_done ##1 !strap_take;
    endproperty
    a_strap_once: assert property (p_strap_once) else $error("mode pins sampled twice"); // [R9]

    property p_other_pll;
        @(posedge CLK) disable iff (!RESET_N)
        strap_take && sync2[2:0] == 3'h3 |=> cfg[`CFG_PLL_EN_BIT] && mult_q == 6'h10;
    endproperty
    a_other_pll: assert property (p_other_pll) else $error("pin code 011 not PLL times four"); // [R11]

endmodule

// *** testbench/ref_clock_source.sv ***
/*
 * Reference clock source model: a free-running oscillator.
 * Assumes a 1ns/1ps time base; phase is unrelated to the system clock.
 */
`timescale 1ns/1ps

module ref_clock_source #(
    parameter real HALF_NS = 800.0,
    parameter real PHASE_NS = 7.0
) (
    output logic REF_CLK
);
    // =====================================================================
    // Oscillator, runs whether or not the device uses it
    initial begin
        REF_CLK = 1'b0;
        #(PHASE_NS);
        forever #(HALF_NS) REF_CLK = ~REF_CLK;
    end
endmodule

// *** testbench/test_machine_clock_generator.sv ***
/*
 * Self-checking bench of the machine clock generator.
 * Assumes the reference period is 40 system clocks and a short lock count.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end

module test_machine_clock_generator;
    import clkgen_pkg::*;
    localparam int LOCKN = 20;
    localparam int WIN = 1280;
    logic CLK = 1'b0, RESET_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, HREADYOUT, HRESP;
    logic [11:0] HADDR = 12'h000;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0, HRDATA, e, m;
    logic A = 1'b0, B = 1'b0, C = 1'b0, REF, MC, MCO, LOCKED, rd_ph = 1'b0;
    logic [31:0] exp_q[$], msk_q[$];
    int q_mc[$], q_out[$];
    int n_mismatch = 0, total_checks = 0, mc, oc, em, eo, k, seed, mq;
    logic pm, po;
    event go;
    int tbl[8] = '{16, 64, 96, 128, 160, 8, 32, 16};
    int mults[9] = '{4, 6, 9, 15, 60, 2, 0, 0, 0};

    always #20 CLK = ~CLK;
    ref_clock_source #(.HALF_NS(800.0), .PHASE_NS(7.0)) partner (.REF_CLK(REF));
    machine_clock_generator #(.LOCK_CYCLES(LOCKN)) DUT (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .REFERENCE_CLOCK_INPUT(REF), .MODE_SELECT_PIN_A(A), .MODE_SELECT_PIN_B(B),
        .MODE_SELECT_PIN_C(C), .MACHINE_CLOCK(MC), .MACHINE_CLOCK_OUTPUT(MCO), .PLL_LOCKED(LOCKED));

    // =====================================================================
    // Closing report
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge CLK);
        n_mismatch++;
        summarize();
    end

    // =====================================================================
    // Bus master
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        if (HREADYOUT !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
    endtask

    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] x, input logic [31:0] xm);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= a;
        if (!w) begin
            exp_q.push_back(x);
            msk_q.push_back(xm);
        end
        wait_rdy();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
    endtask

    // Read results leave the queue as each data phase completes
    always @(posedge CLK) begin
        if (rd_ph && HREADYOUT === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK(HRDATA & m, e & m)
            `CHK(HRESP, 1'b0)
        end
        rd_ph = HSEL && HTRANS[1] && !HWRITE && HREADYOUT;
    end

    // =====================================================================
    // Rate watcher: rising edges of both clocks over one window
    task automatic measure(input int xm, input int xo);
        q_mc.push_back(xm);
        q_out.push_back(xo);
        -> go;
        repeat (WIN + 2) @(posedge CLK);
    endtask

    always begin
        @(go);
        mc = 0;
        oc = 0;
        pm = MC;
        po = MCO;
        repeat (WIN) begin
            @(posedge CLK);
            mc += (MC === 1'b1 && pm === 1'b0);
            oc += (MCO === 1'b1 && po === 1'b0);
            pm = MC;
            po = MCO;
        end
        em = q_mc.pop_front();
        eo = q_out.pop_front();
        `CHK(mc >= em - 1 && mc <= em + 1, 1'b1)
        `CHK(oc >= eo - 1 && oc <= eo + 1, 1'b1)
    end

    task automatic do_reset(input logic [2:0] code);
        @(posedge CLK);
        RESET_N <= 1'b0;
        {A, B, C} <= code;
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (160) @(posedge CLK);
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        seed = $urandom(83);
        for (int i = 6; i < 9; i++) mults[i] = 4 + $urandom % 60;
        for (int c = 0; c < 8; c++) begin
            do_reset(c[2:0]);
            ahb(1'b0, 12'h004, 32'h0, {29'h0, 1'b1, !(c == 0 || c == 5 || c == 7), 1'b0}, 32'h6);
            measure(tbl[c], tbl[c] / 4);
            $display("test strap code %0d done", c);
        end
        do_reset(3'h0);
        ahb(1'b0, 12'h008, 32'h0, 32'h3, 32'h3);
        for (int f = 0; f < 4; f++) begin
            ahb(1'b1, 12'h008, f, 32'h0, 32'h0);
            measure(16, 16 / (f + 1));
        end
        $display("test output divider done");
        ahb(1'b1, 12'h000, 32'h2, 32'h0, 32'h0);
        measure(8, 2);
        $display("test register divide done");
        for (int i = 0; i < 9; i++) begin
            mq = mults[i];
            ahb(1'b1, 12'h000, (mq << 4) | 1, 32'h0, 32'h0);
            repeat (2) @(posedge CLK);
            `CHK(LOCKED, 1'b0)
            k = 0;
            while (LOCKED !== 1'b1 && k < 100) begin
                @(posedge CLK);
                k++;
            end
            `CHK(k >= LOCKN - 4 && k <= LOCKN + 2, 1'b1)
            ahb(1'b0, 12'h000, 32'h0, (mq << 4) | 1, 32'h3f3);
            measure(8 * (mq < 4 ? 4 : mq), 2 * (mq < 4 ? 4 : mq));
            $display("test multiplier %0d done", mq);
        end
        ahb(1'b1, 12'h00c, 32'hffffffff, 32'h0, 32'h0);
        ahb(1'b0, 12'h00c, 32'h0, 32'h0, 32'hffffffff);
        repeat (4) @(posedge CLK);
        $display("test unmapped address done");
        summarize();
    end
endmodule
